// ---- hdl/shwbc_pkg.sv ----
package shwbc_pkg;

  // Register addresses carried in the 7-bit address field of a frame.
  localparam logic [6:0] ADDR_HW_CONFIG   = 7'h02;
  localparam logic [6:0] ADDR_WATCHDOG    = 7'h03;
  localparam logic [6:0] ADDR_BUS_CTRL_A  = 7'h04;

  // Frame layout.
  localparam int         FRAME_BITS       = 16;
  localparam int         ACCESS_BIT       = 7;

  // Hardware configuration control fields.
  localparam int         HW_AUX_LEVEL_BIT = 7;
  localparam int         HW_SOFT_PULSE_BIT = 6;
  localparam int         HW_FAIL_SW_BIT   = 5;
  localparam int         HW_UV_KEEP_BIT   = 4;
  localparam int         HW_LOAD_SHARE_BIT = 3;
  localparam int         HW_STOP_SHARE_BIT = 1;
  localparam int         HW_TOLERANCE_BIT = 0;
  localparam logic [7:0] HW_WRITE_MASK    = 8'hfb;
  localparam logic [7:0] HW_POR_VALUE     = 8'h00;
  localparam logic [7:0] HW_SOFT_KEEP     = 8'h88;
  localparam logic [7:0] HW_RESTART_KEEP  = 8'hd9;

  // Watchdog control fields.
  localparam int         WD_STOP_OFF_BIT  = 6;
  localparam int         WD_WINDOW_BIT    = 5;
  localparam int         WD_BUS_WAKE_BIT  = 4;
  localparam int         WD_PERIOD_MSB    = 2;
  localparam logic [7:0] WD_WRITE_MASK    = 8'hf7;
  localparam logic [7:0] WD_RESET_VALUE   = 8'h14;
  localparam logic [7:0] WD_RESTART_KEEP  = 8'hb0;
  localparam logic [7:0] WD_RESTART_SET   = 8'h04;
  localparam logic [2:0] WD_PERIOD_LAST   = 3'h5;

  // Bus transceiver control fields.
  localparam int         BUS_FLASH_BIT    = 7;
  localparam int         BUS_SLOPE_BIT    = 6;
  localparam int         BUS_TIMEOUT_BIT  = 5;
  localparam int         BUS_WIRE_LSB     = 3;
  localparam logic [7:0] BUS_WRITE_MASK   = 8'hfb;
  localparam logic [7:0] BUS_RESET_VALUE  = 8'h20;
  localparam logic [4:0] BUS_FAILSAFE_LOW = 5'h09;

  // Transceiver mode codes.
  localparam logic [1:0] XCVR_OFF         = 2'h0;
  localparam logic [1:0] XCVR_WAKE        = 2'h1;
  localparam logic [1:0] XCVR_RX_ONLY     = 2'h2;
  localparam logic [1:0] XCVR_NORMAL      = 2'h3;

  // Timing.
  localparam int         SYS_CLK_MHZ      = 125;
  localparam int         RESET_PULSE_NS   = 1000;
  localparam int         RESET_PULSE_CYCLES = (RESET_PULSE_NS * SYS_CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    SHWBC_IDLE  = 2'b01,
    SHWBC_FRAME = 2'b10
  } shwbc_state_t;

endpackage : shwbc_pkg

// ---- hdl/shwbc_sync.sv ----
`timescale 1ns/1ns
module shwbc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             sys_rst,
  input  wire logic             clkEn,
  input  wire logic [WIDTH-1:0] asyncIn,
  input  wire logic [WIDTH-1:0] resetValue,
  output logic      [WIDTH-1:0] syncOut
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;

  // Both stages hold the input relative to its idle level, so a zero reset shows idle.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      stage1 <= '0;
      stage2 <= '0;
    end else if (clkEn) begin
      stage1 <= asyncIn ^ resetValue;
      stage2 <= stage1;
    end
  end

  assign syncOut = stage2 ^ resetValue;

endmodule : shwbc_sync

// ---- hdl/shwbc_regs.sv ----
`timescale 1ns/1ns
// Functional notes
// - Bit 7 of hardware config picks aux regulator level: main level or fixed lower.
// - Bit 6 clear pulls reset output low during soft reset; set leaves it.
// - Bit 5 set activates failure outputs by software; clear leaves events only.
// - Event-driven failure outputs stay on until the global failure flag is cleared.
// - Entering restart clears the software failure bit and drops its outputs.
// - Bit 4 clear switches aux regulator off at battery undervoltage.
// - Bit 3 selects stand-alone or load-sharing aux regulator topology.
// - Bit 1 enables load sharing in stop mode and high-power phases.
// - Bit 0 sets watchdog tolerance: second failure at 0, first at 1.
// - Reserved bits read zero: config bit 2, watchdog bit 3, bus bit 2.
// - Power-on clears config; soft reset clears all but bits 7 and 3.
// - Host sets watchdog bit 7 for even parity; device uses it only as checksum.
// - Watchdog bit 6 set requests watchdog off during stop mode.
// - Watchdog bit 5 selects time-out or window watchdog.
// - Watchdog bit 4 set starts watchdog with long open window after bus wake.
// - Watchdog bits 2:0 pick period 10 to 500 ms; 110 undefined, 111 reserved.
// - Reset loads watchdog 0x14; restart clears bits 6, 3, forces period 100.
// - Bus control holds flash, slope, timeout, wire mode, CAN mode; resets 0x20.
// - Restart keeps bus bits 7:5, clears bit 2, mode fields from restart cause.
// - Stop-mode share enable also governs main regulator peak handling in stop.
// - Frame is 7-bit address, access bit 7 (1 write), then data byte.
// - Transceiver mode codes: off, wake capable, receive only, normal.
// - Flash, slope and timeout changes take effect when chip select rises.
// - Fail-safe entry reloads bus control with xxx0 1001.
module shwbc_regs
  import shwbc_pkg::*;
#(
  parameter int PULSE_CYCLES = RESET_PULSE_CYCLES
) (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       clkEn,
  input  wire logic       spiClk,
  input  wire logic       chipSelectLowActive,
  input  wire logic       spiDataIn,
  output logic            spiDataOut,
  output logic            spiDataOutEn,
  input  wire logic       batteryUndervoltage,
  input  wire logic       auxRegRequest,
  input  wire logic       softResetPulse,
  input  wire logic       restartPulse,
  input  wire logic       failSafePulse,
  input  wire logic [1:0] restartWireMode,
  input  wire logic [1:0] restartCanMode,
  input  wire logic       failureEvent,
  input  wire logic       failureFlagClear,
  output logic            resetOutputLowActive,
  output logic            failureOutputs,
  output logic            auxRegEnable,
  output logic            auxRegLevelSelect,
  output logic            auxRegLoadShare,
  output logic            auxShareInStopEnable,
  output logic            wdogFirstFailTrips,
  output logic            wdogStopDisableLow,
  output logic            wdogWindowSelect,
  output logic            wdogStartOnBusWake,
  output logic [2:0]      wdogPeriodSelect,
  output logic            wdogPeriodValid,
  output logic            wdogParityOk,
  output logic            flashMode,
  output logic            lowSlopeMode,
  output logic            transmitTimeoutEnable,
  output logic [1:0]      firstSingleWireMode,
  output logic [1:0]      canMode
);

  localparam logic [3:0] PIN_IDLE = 4'b0100;

  logic [3:0]    pinSync;
  logic          sclkS;
  logic          csnS;
  logic          sdiS;
  logic          uvS;
  logic          sclkPrev;
  logic          csnPrev;
  logic          sclkRise;
  logic          sclkFall;
  logic          frameStart;
  logic          frameEnd;
  shwbc_state_t  state;
  logic [4:0]    bitCount;
  logic [15:0]   rxShift;
  logic [7:0]    readByte;
  logic [7:0]    hwConfig;
  logic [7:0]    wdCtrl;
  logic [7:0]    busCtrl;
  logic          failureLatched;
  logic [15:0]   pulseCount;
  logic          commitWrite;
  logic [6:0]    frameAddr;
  logic [7:0]    frameData;
  logic [7:0]    next_readByte;

  shwbc_sync #(
    .WIDTH(4)
  ) u_pin_sync (
    .sys_clk   (sys_clk),
    .sys_rst   (sys_rst),
    .clkEn     (clkEn),
    .asyncIn   ({batteryUndervoltage, chipSelectLowActive, spiDataIn, spiClk}),
    .resetValue(PIN_IDLE),
    .syncOut   (pinSync)
  );

  assign sclkS = pinSync[0];
  assign sdiS  = pinSync[1];
  assign csnS  = pinSync[2];
  assign uvS   = pinSync[3];

  assign sclkRise   = sclkS & ~sclkPrev & (state == SHWBC_FRAME);
  assign sclkFall   = ~sclkS & sclkPrev & (state == SHWBC_FRAME);
  assign frameStart = ~csnS & csnPrev;
  assign frameEnd   = csnS & ~csnPrev & (state == SHWBC_FRAME);
  assign frameAddr  = rxShift[ACCESS_BIT-1:0];
  assign frameData  = rxShift[15:8];

  // A write is only honoured for a frame of exactly sixteen clocks.
  assign commitWrite = frameEnd && (bitCount == 5'(FRAME_BITS)) && rxShift[ACCESS_BIT];

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sclkPrev <= 1'b0;
      csnPrev  <= 1'b1;
    end else if (clkEn) begin
      sclkPrev <= sclkS;
      csnPrev  <= csnS;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state <= SHWBC_IDLE;
    end else if (clkEn) begin
      unique case (state)
        SHWBC_IDLE: begin
          if (frameStart) begin
            state <= SHWBC_FRAME;
          end
        end
        SHWBC_FRAME: begin
          if (csnS) begin
            state <= SHWBC_IDLE;
          end
        end
        default: begin
          state <= SHWBC_IDLE;
        end
      endcase
    end
  end

  // Bits arrive least significant first, so the shifter fills from the top.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bitCount <= 5'h00;
      rxShift  <= 16'h0000;
    end else if (clkEn) begin
      if (frameStart) begin
        bitCount <= 5'h00;
        rxShift  <= 16'h0000;
      end else if (sclkRise) begin
        rxShift <= {sdiS, rxShift[15:1]};
        if (bitCount != 5'h1f) begin
          bitCount <= bitCount + 5'h01;
        end
      end
    end
  end

  always_comb begin
    next_readByte = 8'h00;
    unique case ({sdiS, rxShift[15:10]})
      ADDR_HW_CONFIG:  next_readByte = hwConfig & HW_WRITE_MASK;
      ADDR_WATCHDOG:   next_readByte = wdCtrl & WD_WRITE_MASK;
      ADDR_BUS_CTRL_A: next_readByte = busCtrl & BUS_WRITE_MASK;
      default:         next_readByte = 8'h00;
    endcase
  end

  // The read byte is captured with the seventh address bit, so the reply shows
  // the content held before any write carried by the same frame.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      readByte <= 8'h00;
    end else if (clkEn) begin
      if (sclkRise && (bitCount == 5'h06)) begin
        readByte <= next_readByte;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      spiDataOut   <= 1'b0;
      spiDataOutEn <= 1'b0;
    end else if (clkEn) begin
      spiDataOutEn <= ~csnS;
      if (frameStart) begin
        spiDataOut <= 1'b0;
      end else if (sclkFall) begin
        if (bitCount[4:3] == 2'b01) begin
          spiDataOut <= readByte[bitCount[2:0]];
        end else begin
          spiDataOut <= 1'b0;
        end
      end
    end
  end

  // Hardware events take priority over a host write landing in the same cycle.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      hwConfig <= HW_POR_VALUE;
    end else if (clkEn) begin
      if (softResetPulse) begin
        hwConfig <= hwConfig & HW_SOFT_KEEP;
      end else if (restartPulse) begin
        hwConfig <= hwConfig & HW_RESTART_KEEP;
      end else if (commitWrite && (frameAddr == ADDR_HW_CONFIG)) begin
        hwConfig <= frameData & HW_WRITE_MASK;
      end
    end
  end

  // The checksum bit is stored as written; only the parity flag interprets it.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wdCtrl <= WD_RESET_VALUE;
    end else if (clkEn) begin
      if (softResetPulse) begin
        wdCtrl <= WD_RESET_VALUE;
      end else if (restartPulse) begin
        wdCtrl <= (wdCtrl & WD_RESTART_KEEP) | WD_RESTART_SET;
      end else if (commitWrite && (frameAddr == ADDR_WATCHDOG)) begin
        wdCtrl <= frameData & WD_WRITE_MASK;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      busCtrl <= BUS_RESET_VALUE;
    end else if (clkEn) begin
      if (softResetPulse) begin
        busCtrl <= BUS_RESET_VALUE;
      end else if (failSafePulse) begin
        busCtrl <= {busCtrl[7:5], BUS_FAILSAFE_LOW};
      end else if (restartPulse) begin
        busCtrl <= {busCtrl[7:5], restartWireMode, 1'b0, restartCanMode};
      end else if (commitWrite && (frameAddr == ADDR_BUS_CTRL_A)) begin
        busCtrl <= frameData & BUS_WRITE_MASK;
      end
    end
  end

  // A failure event arriving with the clear wins, so no event is lost.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      failureLatched <= 1'b0;
    end else if (clkEn) begin
      if (failureEvent) begin
        failureLatched <= 1'b1;
      end else if (failureFlagClear) begin
        failureLatched <= 1'b0;
      end
    end
  end

  // The pulse decision uses the setting held just before the soft reset clears it.
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pulseCount <= 16'h0000;
    end else if (clkEn) begin
      if (softResetPulse && !hwConfig[HW_SOFT_PULSE_BIT]) begin
        pulseCount <= 16'(PULSE_CYCLES);
      end else if (pulseCount != 16'h0000) begin
        pulseCount <= pulseCount - 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      resetOutputLowActive <= 1'b1;
      failureOutputs       <= 1'b0;
      auxRegEnable         <= 1'b0;
      auxRegLevelSelect    <= 1'b0;
      auxRegLoadShare      <= 1'b0;
      auxShareInStopEnable <= 1'b0;
      wdogFirstFailTrips   <= 1'b0;
    end else if (clkEn) begin
      resetOutputLowActive <= (pulseCount == 16'h0000);
      failureOutputs       <= hwConfig[HW_FAIL_SW_BIT] | failureLatched;
      auxRegEnable         <= auxRegRequest & (~uvS | hwConfig[HW_UV_KEEP_BIT]);
      auxRegLevelSelect    <= hwConfig[HW_AUX_LEVEL_BIT];
      auxRegLoadShare      <= hwConfig[HW_LOAD_SHARE_BIT];
      // One bit drives both stop-mode sharing and the main regulator peak handling.
      auxShareInStopEnable <= hwConfig[HW_STOP_SHARE_BIT];
      wdogFirstFailTrips   <= hwConfig[HW_TOLERANCE_BIT];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      wdogStopDisableLow <= 1'b0;
      wdogWindowSelect   <= 1'b0;
      wdogStartOnBusWake <= 1'b1;
      wdogPeriodSelect   <= 3'h4;
      wdogPeriodValid    <= 1'b1;
      wdogParityOk       <= 1'b1;
    end else if (clkEn) begin
      wdogStopDisableLow <= wdCtrl[WD_STOP_OFF_BIT];
      wdogWindowSelect   <= wdCtrl[WD_WINDOW_BIT];
      wdogStartOnBusWake <= wdCtrl[WD_BUS_WAKE_BIT];
      wdogPeriodSelect   <= wdCtrl[WD_PERIOD_MSB:0];
      // Codes above the last listed period are flagged so the timer can refuse them.
      wdogPeriodValid    <= (wdCtrl[WD_PERIOD_MSB:0] <= WD_PERIOD_LAST);
      wdogParityOk       <= ~(^wdCtrl);
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      flashMode             <= 1'b0;
      lowSlopeMode          <= 1'b0;
      transmitTimeoutEnable <= 1'b1;
      firstSingleWireMode   <= XCVR_OFF;
      canMode               <= XCVR_OFF;
    end else if (clkEn) begin
      flashMode             <= busCtrl[BUS_FLASH_BIT];
      lowSlopeMode          <= busCtrl[BUS_SLOPE_BIT];
      transmitTimeoutEnable <= busCtrl[BUS_TIMEOUT_BIT];
      firstSingleWireMode   <= busCtrl[BUS_WIRE_LSB+1:BUS_WIRE_LSB];
      canMode               <= busCtrl[1:0];
    end
  end

endmodule : shwbc_regs

// ---- dv/shwbc_host_model.sv ----
`timescale 1ns/1ns
module shwbc_host_model (
  input  wire logic sys_clk,
  input  wire logic spiDataOut,
  output logic      spiClk,
  output logic      chipSelectLowActive,
  output logic      spiDataIn
);
  initial begin
    spiClk = 1'b0;
    chipSelectLowActive = 1'b1;
    spiDataIn = 1'b0;
  end

  // Ten system cycles per half period give the 160 ns link clock.
  task automatic frame(input logic [6:0] a, input logic w, input logic [7:0] d,
                       input int n, output logic [7:0] r);
    logic [15:0] word;
    word = {d, w, a};
    r = 8'h00;
    @(posedge sys_clk);
    chipSelectLowActive <= 1'b0;
    for (int i = 0; i < n; i++) begin
      spiDataIn <= word[i];
      repeat (10) @(posedge sys_clk);
      if (i > 7) r[i-8] = spiDataOut;
      spiClk <= 1'b1;
      repeat (10) @(posedge sys_clk);
      spiClk <= 1'b0;
    end
    repeat (10) @(posedge sys_clk);
    chipSelectLowActive <= 1'b1;
    // The released data line shows the inverse so a stale bit is never trusted.
    spiDataIn <= ~word[15];
    repeat (10) @(posedge sys_clk);
  endtask : frame
endmodule : shwbc_host_model

// ---- dv/shwbc_regs_checker.sv ----
`timescale 1ns/1ns
module shwbc_regs_checker
  import shwbc_pkg::*;
#(
  parameter int PULSE_CYCLES = RESET_PULSE_CYCLES
) (
  input wire logic       sys_clk,
  input wire logic       sys_rst,
  input wire logic       chipSelectLowActive,
  input wire logic       spiDataOutEn,
  input wire logic       batteryUndervoltage,
  input wire logic       auxRegRequest,
  input wire logic       softResetPulse,
  input wire logic       restartPulse,
  input wire logic       failSafePulse,
  input wire logic [1:0] restartWireMode,
  input wire logic [1:0] restartCanMode,
  input wire logic       failureEvent,
  input wire logic       failureFlagClear,
  input wire logic       resetOutputLowActive,
  input wire logic       failureOutputs,
  input wire logic       auxRegEnable,
  input wire logic       auxRegLoadShare,
  input wire logic       wdogStopDisableLow,
  input wire logic       wdogStartOnBusWake,
  input wire logic [2:0] wdogPeriodSelect,
  input wire logic       wdogPeriodValid,
  input wire logic       transmitTimeoutEnable,
  input wire logic       flashMode,
  input wire logic [1:0] firstSingleWireMode,
  input wire logic [1:0] canMode
);
  logic [15:0] lowCount;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) lowCount <= 16'h0000;
    else if (resetOutputLowActive) lowCount <= 16'h0000;
    else lowCount <= lowCount + 16'h0001;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_out_en_idle: assert property (chipSelectLowActive[*6] |-> !spiDataOutEn)
    else $error("data out enabled outside a frame");
  a_aux_unrequested: assert property (!auxRegRequest |=> !auxRegEnable)
    else $error("aux regulator on without request");
  a_aux_no_uv: assert property ((auxRegRequest && !batteryUndervoltage)[*5] |=> auxRegEnable)
    else $error("aux regulator off without undervoltage");
  a_period_valid: assert property (wdogPeriodValid == (wdogPeriodSelect <= 3'h5))
    else $error("period valid flag wrong");
  a_fail_latch: assert property (failureEvent ##1 !failureFlagClear |=> failureOutputs)
    else $error("failure outputs not held after event");
  a_pulse_cause: assert property ($fell(resetOutputLowActive) |->
      $past(softResetPulse, 2) || $past(softResetPulse, 3))
    else $error("reset output low without soft reset");
  a_pulse_len: assert property ($rose(resetOutputLowActive) |-> lowCount == 16'(PULSE_CYCLES))
    else $error("reset output pulse length wrong");
  a_failsafe_wake: assert property (failSafePulse && !softResetPulse |-> ##2
      firstSingleWireMode == XCVR_WAKE && canMode == XCVR_WAKE && flashMode == $past(flashMode))
    else $error("fail-safe bus value wrong");
  a_restart_vals: assert property (restartPulse && !failSafePulse && !softResetPulse |-> ##2
      firstSingleWireMode == $past(restartWireMode, 2) && canMode == $past(restartCanMode, 2)
      && wdogPeriodSelect == 3'h4 && !wdogStopDisableLow)
    else $error("restart values wrong");
  a_soft_defaults: assert property (softResetPulse |-> ##2 wdogPeriodSelect == 3'h4
      && wdogStartOnBusWake && transmitTimeoutEnable && canMode == 2'h0
      && auxRegLoadShare == $past(auxRegLoadShare))
    else $error("soft reset values wrong");
endmodule : shwbc_regs_checker

bind shwbc_regs shwbc_regs_checker #(
  .PULSE_CYCLES(PULSE_CYCLES)
) u_chk (
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .chipSelectLowActive(chipSelectLowActive),
  .spiDataOutEn(spiDataOutEn),
  .batteryUndervoltage(batteryUndervoltage),
  .auxRegRequest(auxRegRequest),
  .softResetPulse(softResetPulse),
  .restartPulse(restartPulse),
  .failSafePulse(failSafePulse),
  .restartWireMode(restartWireMode),
  .restartCanMode(restartCanMode),
  .failureEvent(failureEvent),
  .failureFlagClear(failureFlagClear),
  .resetOutputLowActive(resetOutputLowActive),
  .failureOutputs(failureOutputs),
  .auxRegEnable(auxRegEnable),
  .auxRegLoadShare(auxRegLoadShare),
  .wdogStopDisableLow(wdogStopDisableLow),
  .wdogStartOnBusWake(wdogStartOnBusWake),
  .wdogPeriodSelect(wdogPeriodSelect),
  .wdogPeriodValid(wdogPeriodValid),
  .transmitTimeoutEnable(transmitTimeoutEnable),
  .flashMode(flashMode),
  .firstSingleWireMode(firstSingleWireMode),
  .canMode(canMode)
);

// ---- dv/shwbc_regs_tb.sv ----
`timescale 1ns/1ns
module shwbc_regs_tb
  import shwbc_pkg::*;
;
  localparam int PC = 4;
  logic       sys_clk = 1'b0;
  logic       sys_rst = 1'b1;
  logic       clkEn = 1'b1;
  logic       batteryUndervoltage = 1'b1;
  logic       auxRegRequest = 1'b1;
  logic [4:0] ev = 5'h00;
  logic [1:0] restartWireMode = 2'h2;
  logic [1:0] restartCanMode = 2'h1;
  wire        softResetPulse = ev[0];
  wire        restartPulse = ev[1];
  wire        failSafePulse = ev[2];
  wire        failureEvent = ev[3];
  wire        failureFlagClear = ev[4];
  logic       spiClk, chipSelectLowActive, spiDataIn, spiDataOut, spiDataOutEn;
  logic       resetOutputLowActive, failureOutputs, auxRegEnable, auxRegLevelSelect;
  logic       auxRegLoadShare, auxShareInStopEnable, wdogFirstFailTrips, wdogStopDisableLow;
  logic       wdogWindowSelect, wdogStartOnBusWake, wdogPeriodValid, wdogParityOk;
  logic       flashMode, lowSlopeMode, transmitTimeoutEnable;
  logic [2:0] wdogPeriodSelect;
  logic [1:0] firstSingleWireMode, canMode;
  int         numErrors = 0;
  int         samplesChecked = 0;
  int         cycles = 0;

  shwbc_regs #(.PULSE_CYCLES(PC)) u_dut (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .clkEn(clkEn),
    .spiClk(spiClk),
    .chipSelectLowActive(chipSelectLowActive),
    .spiDataIn(spiDataIn),
    .spiDataOut(spiDataOut),
    .spiDataOutEn(spiDataOutEn),
    .batteryUndervoltage(batteryUndervoltage),
    .auxRegRequest(auxRegRequest),
    .softResetPulse(softResetPulse),
    .restartPulse(restartPulse),
    .failSafePulse(failSafePulse),
    .restartWireMode(restartWireMode),
    .restartCanMode(restartCanMode),
    .failureEvent(failureEvent),
    .failureFlagClear(failureFlagClear),
    .resetOutputLowActive(resetOutputLowActive),
    .failureOutputs(failureOutputs),
    .auxRegEnable(auxRegEnable),
    .auxRegLevelSelect(auxRegLevelSelect),
    .auxRegLoadShare(auxRegLoadShare),
    .auxShareInStopEnable(auxShareInStopEnable),
    .wdogFirstFailTrips(wdogFirstFailTrips),
    .wdogStopDisableLow(wdogStopDisableLow),
    .wdogWindowSelect(wdogWindowSelect),
    .wdogStartOnBusWake(wdogStartOnBusWake),
    .wdogPeriodSelect(wdogPeriodSelect),
    .wdogPeriodValid(wdogPeriodValid),
    .wdogParityOk(wdogParityOk),
    .flashMode(flashMode),
    .lowSlopeMode(lowSlopeMode),
    .transmitTimeoutEnable(transmitTimeoutEnable),
    .firstSingleWireMode(firstSingleWireMode),
    .canMode(canMode)
  );
  shwbc_host_model u_host (
    .sys_clk(sys_clk),
    .spiDataOut(spiDataOut),
    .spiClk(spiClk),
    .chipSelectLowActive(chipSelectLowActive),
    .spiDataIn(spiDataIn)
  );

  always #4 sys_clk = ~sys_clk;

  task automatic end_of_test();
    $display("checks %0d errors %0d", samplesChecked, numErrors);
    if (numErrors == 0 && samplesChecked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test

  // A hung frame would stall the bench, so the run is cut short here.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 40000) begin
      numErrors++;
      end_of_test();
    end
  end

  task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      numErrors++;
      $display("wrong value %s expected %h seen %h", n, exp, got);
    end
  endtask : chk

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    u_host.frame(a, 1'b1, d, 16, r);
  endtask : wr

  task automatic rd(input logic [6:0] a, input logic [7:0] e, input string n);
    logic [7:0] r;
    u_host.frame(a, 1'b0, 8'h00, 16, r);
    chk(n, r, e);
  endtask : rd

  task automatic pls(input int i);
    @(posedge sys_clk);
    ev[i] <= 1'b1;
    @(posedge sys_clk);
    ev <= 5'h00;
    repeat (4) @(posedge sys_clk);
  endtask : pls

  function automatic logic [7:0] par(input logic [6:0] v);
    return {^v, v};
  endfunction : par

  task automatic t_reset();
    rd(ADDR_HW_CONFIG, 8'h00, "hw");
    rd(ADDR_WATCHDOG, 8'h14, "wd");
    rd(ADDR_BUS_CTRL_A, 8'h20, "bus");
    $display("test reset done");
  endtask : t_reset

  task automatic t_write();
    logic [7:0] r;
    wr(ADDR_HW_CONFIG, 8'hff);
    rd(ADDR_HW_CONFIG, 8'hfb, "hw");
    chk("hw outs", {auxRegLevelSelect, failureOutputs, auxRegEnable, auxRegLoadShare,
        auxShareInStopEnable, wdogFirstFailTrips}, 8'h3f);
    wr(ADDR_HW_CONFIG, 8'h00);
    chk("hw clear", {failureOutputs, auxRegEnable, auxRegLevelSelect}, 8'h00);
    wr(ADDR_WATCHDOG, 8'hff);
    rd(ADDR_WATCHDOG, 8'hf7, "wd");
    chk("wd outs", {wdogStopDisableLow, wdogWindowSelect, wdogStartOnBusWake,
        wdogPeriodValid, wdogParityOk}, 8'h1c);
    wr(ADDR_BUS_CTRL_A, 8'hff);
    rd(ADDR_BUS_CTRL_A, 8'hfb, "bus");
    chk("bus outs", {flashMode, lowSlopeMode, transmitTimeoutEnable}, 8'h07);
    u_host.frame(ADDR_BUS_CTRL_A, 1'b1, 8'h00, 15, r);
    rd(ADDR_BUS_CTRL_A, 8'hfb, "short");
    wr(7'h10, 8'hff);
    rd(7'h10, 8'h00, "unmapped");
    $display("test write done");
  endtask : t_write

  task automatic t_codes();
    for (int i = 0; i < 8; i++) begin
      wr(ADDR_WATCHDOG, par({4'h0, i[2:0]}));
      wr(ADDR_BUS_CTRL_A, {3'h0, i[1:0], 1'b0, i[1:0]});
      chk("period", {wdogParityOk, wdogPeriodValid, wdogPeriodSelect},
          {3'h1, i < 6, i[2:0]});
      chk("modes", {firstSingleWireMode, canMode}, {4'h0, i[1:0], i[1:0]});
    end
    $display("test codes done");
  endtask : t_codes

  task automatic t_events();
    wr(ADDR_HW_CONFIG, 8'hff);
    wr(ADDR_WATCHDOG, par(7'h75));
    wr(ADDR_BUS_CTRL_A, 8'he3);
    pls(1);
    chk("fail off", {7'h00, failureOutputs}, 8'h00);
    rd(ADDR_HW_CONFIG, 8'hd9, "hw restart");
    rd(ADDR_WATCHDOG, 8'hb4, "wd restart");
    rd(ADDR_BUS_CTRL_A, 8'hf1, "bus restart");
    pls(2);
    rd(ADDR_BUS_CTRL_A, 8'he9, "bus failsafe");
    wr(ADDR_HW_CONFIG, 8'h89);
    @(posedge sys_clk);
    ev[0] <= 1'b1;
    @(posedge sys_clk);
    ev <= 5'h00;
    repeat (3) @(posedge sys_clk);
    #1 chk("pulse low", {7'h00, resetOutputLowActive}, 8'h00);
    repeat (PC + 2) @(posedge sys_clk);
    #1 chk("pulse end", {7'h00, resetOutputLowActive}, 8'h01);
    rd(ADDR_HW_CONFIG, 8'h88, "hw soft");
    rd(ADDR_WATCHDOG, 8'h14, "wd soft");
    rd(ADDR_BUS_CTRL_A, 8'h20, "bus soft");
    $display("test events done");
  endtask : t_events

  task automatic t_fail();
    batteryUndervoltage <= 1'b0;
    wr(ADDR_HW_CONFIG, 8'h20);
    pls(3);
    wr(ADDR_HW_CONFIG, 8'h00);
    chk("latched", {failureOutputs, auxRegEnable}, 8'h03);
    pls(4);
    chk("cleared", {7'h00, failureOutputs}, 8'h00);
    auxRegRequest <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk("unrequested", {7'h00, auxRegEnable}, 8'h00);
    auxRegRequest <= 1'b1;
    repeat (2) @(posedge sys_clk);
    clkEn <= 1'b0;
    batteryUndervoltage <= 1'b1;
    repeat (8) @(posedge sys_clk);
    chk("frozen", {7'h00, auxRegEnable}, 8'h01);
    clkEn <= 1'b1;
    repeat (5) @(posedge sys_clk);
    chk("uv off", {7'h00, auxRegEnable}, 8'h00);
    $display("test fail done");
  endtask : t_fail

  initial begin
    repeat (8) @(posedge sys_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    t_reset();
    t_write();
    t_codes();
    t_events();
    t_fail();
    end_of_test();
  end
endmodule : shwbc_regs_tb
